/* rtl/pis_pkg.sv */
// Purpose: Shared constants and types of the sub-level interrupt flags
// Assumes: 8-bit register port driven by the device's serial target logic
// Notes:   Flag registers clear on write of 1; masks are plain read/write

package pis_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_SYS_MASK   = 8'h03;
   localparam logic [7:0] ADDR_CHG_FLAGS  = 8'h04;
   localparam logic [7:0] ADDR_CHG_MASK   = 8'h05;
   localparam logic [7:0] ADDR_RAIL_FLAGS = 8'h06;
   localparam logic [7:0] ADDR_RAIL_MASK  = 8'h07;

   // ------------------------------------------------------------
   // Reset values and widths
   // ------------------------------------------------------------
   localparam int         SYS_W           = 6;
   localparam int         CHG_W           = 7;
   localparam int         RAIL_W          = 4;
   localparam int         LIN_W           = 2;
   localparam logic [7:0] SYS_MASK_RST    = 8'h3f;
   localparam logic [7:0] CHG_MASK_RST    = 8'h7f;
   localparam logic [7:0] RAIL_MASK_RST   = 8'hff;
   localparam logic [7:0] RD_UNMAPPED     = 8'h00;

   // ------------------------------------------------------------
   // Charger flag positions
   // ------------------------------------------------------------
   localparam int CHG_DEAD_BIT   = 6;
   localparam int CHG_ILIM_BIT   = 5;
   localparam int CHG_FAST_BIT   = 4;
   localparam int CHG_PREQ_BIT   = 3;
   localparam int CHG_BATT_BIT   = 2;
   localparam int CHG_VGOOD_BIT  = 1;
   localparam int CHG_GOOD_BIT   = 0;

   // ------------------------------------------------------------
   // Rail flag positions
   // ------------------------------------------------------------
   localparam int RAIL_BUCK1_BIT = 3;
   localparam int RAIL_BUCK2_BIT = 2;
   localparam int RAIL_LIN1_BIT  = 1;
   localparam int RAIL_LIN2_BIT  = 0;

   // Cycles after reset release before change detection starts
   localparam int ARM_CYCLES     = 3;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic deadTimer;
      logic inputLimit;
      logic fastTimer;
      logic prequalTimer;
   } pis_chg_evt_t;

   typedef struct packed {
      logic battPresent;
      logic battVoltGood;
      logic chargerGood;
      logic buck1Good;
      logic buck2Good;
      logic linreg1Good;
      logic linreg2Good;
   } pis_status_t;

   typedef struct packed {
      logic sysGroup;
      logic chargerGroup;
      logic buckGroup;
      logic linregGroup;
   } pis_group_t;

endpackage : pis_pkg

/* rtl/pis_flags_top.sv */
// Purpose: Sub-level interrupt flags, masks, group summary and irq line
// Assumes: Status and timer inputs arrive from outside the clock domain
// Notes:   Register port is synchronous to clk_sys
//
// What this block does
// [RULE1] System mask holds six event mask bits
// [RULE2] Mask one blocks event, zero passes it
// [RULE3] Unmasked charger flags set charger group bit
// [RULE4] Bit 6 latches dead timer expiry
// [RULE5] Bit 5 latches input current limiting
// [RULE6] Bit 4 latches fast-charge timer expiry
// [RULE7] Bit 3 latches pre-qualification timer expiry
// [RULE8] Bit 2 latches battery-present status change
// [RULE9] Bit 1 latches battery-voltage-good change
// [RULE10] Bit 0 latches charger-good status change
// [RULE11] Flag registers clear on host write
// [RULE12] Charger mask bits 6..0 reset masked
// [RULE13] Unmasked rail flags drive buck, linreg groups
// [RULE14] Rail bit 3 latches buck1 good change
// [RULE15] Rail bit 2 latches buck2 good change
// [RULE16] Rail bits 1,0 latch linreg changes
// [RULE17] Group bit clears after all group flags
// [RULE18] Irq line asserts on first unmasked event
// [RULE19] Rail mask bits 3..0 reset masked
// [RULE20] Write one clears; coincident event wins

`timescale 1ns/1ns

module pis_flags_top
   import pis_pkg::*;
#(
   parameter int SYNC_DEPTH = 2
) (
   input  wire logic                  clk_sys,
   input  wire logic                  reset_n,
   input  wire logic [7:0]            regAddr,
   input  wire logic [7:0]            regWrData,
   input  wire logic                  regWrEn,
   input  wire logic                  regRdEn,
   output      logic [7:0]            regRdData,
   input  wire pis_chg_evt_t          chgTimerIn,
   input  wire pis_status_t           statusIn,
   input  wire logic [SYS_W-1:0]      sysFlags,
   output      pis_group_t            groupBits,
   output      logic                  irqLineOut,
   output      logic                  irqLineOe
);

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   if (SYNC_DEPTH < 2) begin : gBadDepth
      $error("SYNC_DEPTH must be at least 2");
   end

   localparam int IN_W  = $bits(pis_chg_evt_t) + $bits(pis_status_t);
   localparam int ARM_W = ARM_CYCLES + SYNC_DEPTH - 2;

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rstSync1_q;
   logic rstSync2_q;
   logic rstN;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rstSync1_q <= 1'b0;
         rstSync2_q <= 1'b0;
      end else begin
         rstSync1_q <= 1'b1;
         rstSync2_q <= rstSync1_q;
      end
   end
   assign rstN = rstSync2_q;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [IN_W-1:0] rawIn;
   logic [IN_W-1:0] syncChain_q [SYNC_DEPTH];
   logic [IN_W-1:0] syncIn;
   logic [IN_W-1:0] prevIn_q;
   logic [ARM_W-1:0] arm_q;
   logic            armed;

   assign rawIn = {chgTimerIn, statusIn};

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         for (int i = 0; i < SYNC_DEPTH; i++) begin
            syncChain_q[i] <= '0;
         end
      end else begin
         syncChain_q[0] <= rawIn;
         for (int i = 1; i < SYNC_DEPTH; i++) begin
            syncChain_q[i] <= syncChain_q[i-1];
         end
      end
   end
   assign syncIn = syncChain_q[SYNC_DEPTH-1];

   // Change detection waits until the chain holds real samples
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         prevIn_q <= '0;
         arm_q    <= '0;
      end else begin
         prevIn_q <= syncIn;
         arm_q    <= {arm_q[ARM_W-2:0], 1'b1};
      end
   end
   assign armed = arm_q[ARM_W-1];

   // ------------------------------------------------------------
   // Event detection
   // ------------------------------------------------------------
   pis_chg_evt_t     tmrNow;
   pis_chg_evt_t     tmrPrev;
   pis_status_t      stNow;
   pis_status_t      stPrev;
   logic [CHG_W-1:0] chgEvt;
   logic [RAIL_W-1:0] railEvt;

   assign {tmrNow, stNow}   = syncIn;
   assign {tmrPrev, stPrev} = prevIn_q;

   always_comb begin
      chgEvt  = '0;
      railEvt = '0;
      if (armed) begin
         chgEvt[CHG_DEAD_BIT]  = tmrNow.deadTimer
                                 & ~tmrPrev.deadTimer;       // [RULE4]
         chgEvt[CHG_ILIM_BIT]  = tmrNow.inputLimit
                                 & ~tmrPrev.inputLimit;      // [RULE5]
         chgEvt[CHG_FAST_BIT]  = tmrNow.fastTimer
                                 & ~tmrPrev.fastTimer;       // [RULE6]
         chgEvt[CHG_PREQ_BIT]  = tmrNow.prequalTimer
                                 & ~tmrPrev.prequalTimer;    // [RULE7]
         chgEvt[CHG_BATT_BIT]  = stNow.battPresent
                                 ^ stPrev.battPresent;       // [RULE8]
         chgEvt[CHG_VGOOD_BIT] = stNow.battVoltGood
                                 ^ stPrev.battVoltGood;      // [RULE9]
         chgEvt[CHG_GOOD_BIT]  = stNow.chargerGood
                                 ^ stPrev.chargerGood;       // [RULE10]
         railEvt[RAIL_BUCK1_BIT] = stNow.buck1Good
                                   ^ stPrev.buck1Good;       // [RULE14]
         railEvt[RAIL_BUCK2_BIT] = stNow.buck2Good
                                   ^ stPrev.buck2Good;       // [RULE15]
         railEvt[RAIL_LIN1_BIT]  = stNow.linreg1Good
                                   ^ stPrev.linreg1Good;     // [RULE16]
         railEvt[RAIL_LIN2_BIT]  = stNow.linreg2Good
                                   ^ stPrev.linreg2Good;     // [RULE16]
      end
   end

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   logic [7:0]        sysMask_q;
   logic [7:0]        chgMask_q;
   logic [7:0]        railMask_q;
   logic [CHG_W-1:0]  chgFlags_q;
   logic [RAIL_W-1:0] railFlags_q;
   logic              wrChgFlags;
   logic              wrRailFlags;
   logic [CHG_W-1:0]  chgClr;
   logic [RAIL_W-1:0] railClr;

   assign wrChgFlags  = regWrEn && (regAddr == ADDR_CHG_FLAGS);
   assign wrRailFlags = regWrEn && (regAddr == ADDR_RAIL_FLAGS);
   assign chgClr  = wrChgFlags  ? regWrData[CHG_W-1:0]  : '0; // [RULE11]
   assign railClr = wrRailFlags ? regWrData[RAIL_W-1:0] : '0; // [RULE11]

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         sysMask_q  <= SYS_MASK_RST;                           // [RULE1]
         chgMask_q  <= CHG_MASK_RST;                           // [RULE12]
         railMask_q <= RAIL_MASK_RST;                          // [RULE19]
      end else if (regWrEn) begin
         if (regAddr == ADDR_SYS_MASK) begin
            sysMask_q <= regWrData;                            // [RULE2]
         end
         if (regAddr == ADDR_CHG_MASK) begin
            chgMask_q <= regWrData;                            // [RULE12]
         end
         if (regAddr == ADDR_RAIL_MASK) begin
            railMask_q <= regWrData;                           // [RULE19]
         end
      end
   end

   // Sticky flags: a new event wins over a clear in the same cycle
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         chgFlags_q  <= '0;                                    // [RULE11]
         railFlags_q <= '0;                                    // [RULE11]
      end else begin
         chgFlags_q  <= chgEvt | (chgFlags_q & ~chgClr);       // [RULE20]
         railFlags_q <= railEvt | (railFlags_q & ~railClr);    // [RULE20]
      end
   end

   // ------------------------------------------------------------
   // Register reads
   // ------------------------------------------------------------
   logic [7:0] rdData_d;
   logic [7:0] regRdData_q;

   always_comb begin
      case (regAddr)
         ADDR_SYS_MASK:   rdData_d = sysMask_q;
         ADDR_CHG_FLAGS:  rdData_d = {1'b0, chgFlags_q};
         ADDR_CHG_MASK:   rdData_d = chgMask_q;
         ADDR_RAIL_FLAGS: rdData_d = {4'h0, railFlags_q};
         ADDR_RAIL_MASK:  rdData_d = railMask_q;
         default:         rdData_d = RD_UNMAPPED;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         regRdData_q <= '0;
      end else if (regRdEn) begin
         regRdData_q <= rdData_d;
      end
   end
   assign regRdData = regRdData_q;

   // ------------------------------------------------------------
   // Group summary and interrupt line
   // ------------------------------------------------------------
   pis_group_t group_d;
   pis_group_t group_q;
   logic       irqOe_q;
   logic       irqOut_q;

   always_comb begin
      group_d.sysGroup     = |(sysFlags & ~sysMask_q[SYS_W-1:0]); // [RULE2]
      group_d.chargerGroup = |(chgFlags_q
                               & ~chgMask_q[CHG_W-1:0]);    // [RULE3]
      group_d.buckGroup    = |(railFlags_q[RAIL_W-1:LIN_W]
                               & ~railMask_q[RAIL_W-1:LIN_W]); // [RULE13]
      group_d.linregGroup  = |(railFlags_q[LIN_W-1:0]
                               & ~railMask_q[LIN_W-1:0]);   // [RULE13]
   end

   // Group bits fall only once every unmasked flag of the group is gone
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         group_q  <= '0;
         irqOe_q  <= 1'b0;
         irqOut_q <= 1'b0;
      end else begin
         group_q  <= group_d;                                  // [RULE17]
         irqOe_q  <= |group_d;                                 // [RULE18]
         irqOut_q <= 1'b0;
      end
   end

   assign groupBits  = group_q;
   assign irqLineOe  = irqOe_q;
   assign irqLineOut = irqOut_q;

endmodule : pis_flags_top

/* bench/pis_flags_chk.sv */
// Purpose: Port checker for the sub-level interrupt flags
// Assumes: Timing as given for the register port and group outputs
// Notes:   Bound into pis_flags_top
`timescale 1ns/1ns
module pis_flags_chk
   import pis_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       regWrEn,
   input wire logic       regRdEn,
   input wire logic [7:0] regRdData,
   input wire pis_group_t groupBits,
   input wire logic       irqLineOut,
   input wire logic       irqLineOe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_pinLow; irqLineOut == 1'b0; endproperty
   a_pinLow: assert property (p_pinLow)
      else $error("irq drive high");
   property p_irqSum; irqLineOe == (groupBits != 4'h0); endproperty
   a_irqSum: assert property (p_irqSum)
      else $error("irq vs groups");
   property p_sysMask; regWrEn && regAddr == ADDR_SYS_MASK
      && regWrData[5:0] == 6'h3f |-> ##2 !groupBits.sysGroup; endproperty
   a_sysMask: assert property (p_sysMask)
      else $error("sys masked");
   property p_chgMask; regWrEn && regAddr == ADDR_CHG_MASK
      && regWrData[6:0] == 7'h7f |-> ##2 !groupBits.chargerGroup; endproperty
   a_chgMask: assert property (p_chgMask)
      else $error("chg masked");
   property p_railMask; regWrEn && regAddr == ADDR_RAIL_MASK
      && regWrData[3:0] == 4'hf |-> ##2 groupBits[1:0] == 2'b00; endproperty
   a_railMask: assert property (p_railMask)
      else $error("rail masked");
   property p_rsvd; regRdEn && regAddr == ADDR_RAIL_FLAGS
      |=> regRdData[7:4] == 4'h0; endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("rail reserved set");
   property p_rdHold; !regRdEn |=> $stable(regRdData); endproperty
   a_rdHold: assert property (p_rdHold)
      else $error("read data moved");
   property p_wrRd; regWrEn && regAddr == ADDR_SYS_MASK ##1 !regWrEn
      ##1 regRdEn && regAddr == ADDR_SYS_MASK
      |=> regRdData == $past(regWrData, 3); endproperty
   a_wrRd: assert property (p_wrRd)
      else $error("sys mask readback");
   property p_rst; $rose(reset_n) |-> groupBits == 4'h0 && !irqLineOe
      ##1 groupBits == 4'h0; endproperty
   a_rst: assert property (p_rst)
      else $error("groups after reset");
endmodule : pis_flags_chk
bind pis_flags_top pis_flags_chk u_chk (.clk_sys(clk_sys),
   .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
   .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
   .groupBits(groupBits), .irqLineOut(irqLineOut), .irqLineOe(irqLineOe));

/* bench/pis_host_model.sv */
// Purpose: Host side of the register port and the irq pull-up
// Assumes: One byte per strobe, strobe held to the sampling edge
// Notes:   Idle address and data show the inverse of the last value
`timescale 1ns/1ns
module pis_host_model (
   input  wire logic       clk_sys,
   output      logic [7:0] regAddr,
   output      logic [7:0] regWrData,
   output      logic       regWrEn,
   output      logic       regRdEn,
   input  wire logic [7:0] regRdData,
   input  wire logic       irqLineOut,
   input  wire logic       irqLineOe,
   output      logic       irqLineN
);
   assign irqLineN = irqLineOe ? irqLineOut : 1'b1;
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk_sys);
      regRdEn <= 1'b0;
      regAddr <= ~a;
      #1;
      d = regRdData;
   endtask : rd
endmodule : pis_host_model

/* bench/pis_flags_tb.sv */
// Purpose: Random self-checking bench of the sub-level interrupt flags
// Assumes: Inputs held 28 cycles so every change is seen
// Notes:   Model flags and masks kept as plain vectors
`timescale 1ns/1ns
module pis_flags_tb;
   import pis_pkg::*;
   logic clk_sys, reset_n, regWrEn, regRdEn, irqLineOut, irqLineOe, irqLineN;
   logic [7:0] regAddr, regWrData, regRdData, chgF, railF, sysM, chgM, railM;
   pis_chg_evt_t chgTimerIn;
   pis_status_t statusIn;
   pis_group_t groupBits;
   logic [SYS_W-1:0] sysFlags;
   logic [3:0] tmrOld;
   logic [6:0] stOld;
   logic [31:0] seed;
   int err_count, samples_checked;
   pis_host_model host (.clk_sys(clk_sys), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdData(regRdData), .irqLineOut(irqLineOut),
      .irqLineOe(irqLineOe), .irqLineN(irqLineN));
   pis_flags_top uut (.clk_sys(clk_sys), .reset_n(reset_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData(regRdData), .chgTimerIn(chgTimerIn),
      .statusIn(statusIn), .sysFlags(sysFlags), .groupBits(groupBits),
      .irqLineOut(irqLineOut), .irqLineOe(irqLineOe));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [7:0] mk(input int i, input logic [7:0] v);
      return (i % 4 == 0) ? 8'hff : (i % 4 == 1) ? 8'h00 : v;
   endfunction : mk
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check_regs();
      logic [7:0] d;
      host.rd(ADDR_SYS_MASK, d);
      cmp(d, sysM);
      host.rd(ADDR_CHG_FLAGS, d);
      cmp(d, chgF);
      host.rd(ADDR_CHG_MASK, d);
      cmp(d, chgM);
      host.rd(ADDR_RAIL_FLAGS, d);
      cmp(d, railF);
      host.rd(ADDR_RAIL_MASK, d);
      cmp(d, railM);
      host.rd(8'h08, d);
      cmp(d, RD_UNMAPPED);
   endtask : check_regs
   task automatic step(input int i);
      logic [31:0] r;
      logic [31:0] c;
      logic [3:0] g;
      r = xs();
      c = xs();
      @(posedge clk_sys);
      chgTimerIn <= pis_chg_evt_t'(r[3:0]);
      statusIn <= pis_status_t'(r[10:4]);
      sysFlags <= r[16:11];
      @(posedge clk_sys);
      // Charger clear lands on the edge the new events set their flags
      host.wr(ADDR_CHG_FLAGS, c[7:0]);
      host.wr(ADDR_RAIL_FLAGS, c[15:8]);
      chgF[6:3] = (chgF[6:3] & ~c[6:3])
                  | (r[3:0] & ~tmrOld);
      chgF[2:0] = (chgF[2:0] & ~c[2:0])
                  | (r[10:8] ^ stOld[6:4]);
      railF[3:0] = (railF[3:0] | (r[7:4] ^ stOld[3:0]))
                   & ~c[11:8];
      tmrOld = r[3:0];
      stOld = r[10:4];
      r = xs();
      host.wr(ADDR_CHG_FLAGS, r[7:0]);
      chgF = chgF & ~r[7:0];
      host.wr(ADDR_RAIL_FLAGS, r[15:8]);
      railF = railF & ~r[15:8];
      chgM = mk(i, r[31:24]);
      host.wr(ADDR_CHG_MASK, chgM);
      railM = mk(i, r[27:20]);
      host.wr(ADDR_RAIL_MASK, railM);
      sysM = mk(i, r[23:16]);
      host.wr(ADDR_SYS_MASK, sysM);
      check_regs();
      g[3] = |(sysFlags & ~sysM[5:0]);
      g[2] = |(chgF[6:0] & ~chgM[6:0]);
      g[1] = |(railF[3:2] & ~railM[3:2]);
      g[0] = |(railF[1:0] & ~railM[1:0]);
      cmp({4'h0, groupBits}, {4'h0, g});
      cmp({7'h00, irqLineN}, {7'h00, ~|g});
   endtask : step
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      tally_and_finish();
   end
   initial begin
      reset_n = 1'b0;
      chgTimerIn = '0;
      statusIn = '0;
      sysFlags = '0;
      seed = 1;
      err_count = 0;
      samples_checked = 0;
      {chgF, railF, tmrOld, stOld} = '0;
      {sysM, chgM, railM} = {SYS_MASK_RST, CHG_MASK_RST, RAIL_MASK_RST};
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      check_regs();
      for (int i = 0; i < 48; i++) begin
         step(i);
      end
      tally_and_finish();
   end
endmodule : pis_flags_tb
